// ---- dv/l2_cache_lim_scratchpad_tb_top.sv ----
module l2_cache_lim_scratchpad_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] in_req = 4'h0, in_we = 4'h0, in_ack, in_err, prb_v;
  logic [3:0][31:0] in_addr = '0, prb_a;
  logic [3:0][127:0] in_wdata = '0, in_rdata;
  logic [3:0][2:0] in_src = '0;
  logic [3:0][4:0] prb_m;
  logic win_req = 1'b0, win_we = 1'b0, win_ack, win_err, out_req, out_we, out_ack, ecc_err;
  logic [31:0] win_addr = '0, out_addr, pa;
  logic [4:0] pm;
  logic [127:0] win_wdata = '0, win_rdata, out_wdata, out_rdata, rd;
  logic way_en_wr = 1'b0, er, ee, pv, ecc_inject = 1'b0;
  logic [15:0] way_en_wdata = '0, way_mask = '0, way_lock = '0, way_en, ecc_cnt;
  int n_mismatch = 0, n_tests = 0, n_beats = 0;

  l2c_top uut (.core_clk(core_clk), .rst(rst), .in_req(in_req), .in_we(in_we), .in_addr(in_addr),
    .in_wdata(in_wdata), .in_src(in_src), .in_ack(in_ack), .in_err(in_err), .in_rdata(in_rdata),
    .win_req(win_req), .win_we(win_we), .win_addr(win_addr), .win_wdata(win_wdata), .win_ack(win_ack),
    .win_err(win_err), .win_rdata(win_rdata), .out_req(out_req), .out_we(out_we), .out_addr(out_addr),
    .out_wdata(out_wdata), .out_ack(out_ack), .out_rdata(out_rdata), .way_en_wr(way_en_wr),
    .way_en_wdata(way_en_wdata), .way_mask(way_mask), .way_lock(way_lock), .ecc_inject(ecc_inject),
    .way_en(way_en), .prb_v(prb_v), .prb_m(prb_m), .prb_a(prb_a), .ecc_err(ecc_err), .ecc_cnt(ecc_cnt));
  l2c_ddr_model ddr (.core_clk(core_clk), .rst(rst), .out_req(out_req), .out_addr(out_addr),
    .out_ack(out_ack), .out_rdata(out_rdata));

  initial begin
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (out_ack === 1'b1) n_beats++;
  end

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    n_tests++;
    if (exp !== got) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic inner(input int b, input logic we, input logic [31:0] a, input logic [127:0] d);
    int i;
    in_req[b] = 1'b1;
    in_we[b] = we;
    in_addr[b] = a;
    in_wdata[b] = d;
    @(negedge core_clk);
    for (i = 0; i < 300 && in_ack[b] !== 1'b1; i++) @(negedge core_clk);
    if (i == 300) begin
      n_mismatch++;
      test_done();
    end
    in_req[b] = 1'b0;
    rd = in_rdata[b];
    er = in_err[b];
    pv = prb_v[b];
    pm = prb_m[b];
    pa = prb_a[b];
    @(negedge core_clk);
  endtask : inner

  task automatic win(input logic we, input logic [31:0] a, input logic [127:0] d);
    win_req = 1'b1;
    win_we = we;
    win_addr = a;
    win_wdata = d;
    @(negedge core_clk);
    chk("win_ack", 1, win_ack);
    win_req = 1'b0;
    rd = win_rdata;
    er = win_err;
    ee = ecc_err;
    @(negedge core_clk);
  endtask : win

  task automatic en_write(input logic [15:0] v);
    way_en_wr = 1'b1;
    way_en_wdata = v;
    @(negedge core_clk);
    way_en_wr = 1'b0;
    @(negedge core_clk);
  endtask : en_write

  // Second master shares the line, then the first writes it
  task automatic t_probe;
    in_src[1] = 3'h1;
    inner(1, 1'b0, 32'h0A00_0040, 128'h0);
    in_src[1] = 3'h0;
    inner(1, 1'b1, 32'h0A00_0040, 128'hC3);
    chk("probe valid", 1'h1, pv);
    chk("probe masters", 5'h02, pm);
    chk("probe addr", 32'h0A00_0040, pa);
  endtask : t_probe

  task automatic t_ecc;
    ecc_inject = 1'b1;
    win(1'b1, 32'h0800_0010, 128'h3C);
    ecc_inject = 1'b0;
    win(1'b0, 32'h0800_0010, 128'h0);
    chk("ecc data", 128'h3C, rd);
    chk("ecc err", 1'h1, ee);
    chk("ecc count", 16'h0001, ecc_cnt);
  endtask : t_ecc

  // Window and two banks at once; bank 0 must wait one cycle
  task automatic t_parallel;
    in_we = 4'h0;
    in_addr[0] = 32'h8000_0010;
    in_addr[1] = 32'h0A00_0040;
    in_req = 4'h3;
    win_req = 1'b1;
    win_we = 1'b0;
    win_addr = 32'h0800_0000;
    @(negedge core_clk);
    chk("window first", 1'h1, win_ack);
    chk("window data", 128'hA5, win_rdata);
    chk("parallel acks", 4'h2, in_ack);
    win_req = 1'b0;
    in_req = 4'h1;
    @(negedge core_clk);
    chk("stalled ack", 4'h1, in_ack);
    chk("stalled data", {4{32'h8000_0010}}, in_rdata[0]);
    chk("bank1 data", 128'hC3, in_rdata[1]);
    in_req = 4'h0;
    @(negedge core_clk);
  endtask : t_parallel

  task automatic t_reset;
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk("way_en after reset", 16'h0001, way_en);
    chk("ecc count after reset", 16'h0000, ecc_cnt);
  endtask : t_reset

  initial begin
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk("way_en reset", 16'h0001, way_en);
    win(1'b1, 32'h0800_0000, 128'hA5);
    win(1'b1, 32'h081C_00C0, 128'h5A);
    win(1'b0, 32'h0800_0000, 128'h0);
    chk("win way15 data", 128'hA5, rd);
    win(1'b0, 32'h081C_00C0, 128'h0);
    chk("win way1 data", 128'h5A, rd);
    chk("win way1 err", 0, er);
    en_write(16'h0002);
    chk("way_en grow", 16'h0003, way_en);
    win(1'b0, 32'h081C_00C0, 128'h0);
    chk("win enabled err", 1, er);
    en_write(16'h0000);
    chk("way_en sticky", 16'h0003, way_en);
    inner(0, 1'b0, 32'h8000_0010, 128'h0);
    chk("ddr fill data", {4{32'h8000_0010}}, rd);
    chk("ddr beats", 4, n_beats);
    inner(0, 1'b0, 32'h8000_0030, 128'h0);
    chk("hit no beats", 4, n_beats);
    inner(1, 1'b1, 32'h0A00_0040, 128'hC3);
    inner(1, 1'b0, 32'h0A00_0040, 128'h0);
    chk("scratch data", 128'hC3, rd);
    chk("scratch no beats", 4, n_beats);
    t_probe();
    way_mask = 16'hFFFF;
    inner(1, 1'b1, 32'h0A00_1040, 128'h1);
    chk("masked scratch err", 1, er);
    way_mask = 16'h0000;
    way_lock = 16'hFFFF;
    inner(1, 1'b1, 32'h0A00_1040, 128'h1);
    chk("locked alloc err", 1'h1, er);
    way_lock = 16'h0000;
    inner(0, 1'b0, 32'h8000_0040, 128'h0);
    chk("wrong bank err", 1, er);
    t_ecc();
    t_parallel();
    t_reset();
    test_done();
  end
endmodule : l2_cache_lim_scratchpad_tb_top

// ---- dv/l2c_ddr_model.sv ----
module l2c_ddr_model #(
  parameter int DLY = 2
) (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Reset
  input wire logic out_req, // Beat request
  input wire logic [31:0] out_addr, // Beat address
  output logic out_ack, // Beat done
  output logic [127:0] out_rdata // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // Data toggles outside an ack so a stale value never looks valid
  always_ff @(posedge core_clk) begin
    if (rst || out_ack || !out_req) begin
      cnt <= 4'h0;
      out_ack <= 1'b0;
      out_rdata <= rst ? 128'h0 : ~out_rdata;
    end else if (cnt == DLY[3:0]) begin
      out_ack <= 1'b1;
      out_rdata <= {4{out_addr}};
    end else begin
      cnt <= cnt + 4'h1;
      out_rdata <= ~out_rdata;
    end
  end
endmodule : l2c_ddr_model

// ---- hdl/l2c_store.sv ----
module l2c_store #(
  parameter int W = l2c_pkg::DW,
  parameter int IW = 15
) (
  input wire logic core_clk, // Core clock
  input wire logic [IW-1:0] idx, // Word index {way,set,beat}
  input wire logic we, // Write strobe
  input wire logic [W-1:0] wdata, // Write data
  input wire logic inject, // Corrupt check bit of this write
  output logic [W-1:0] rdata, // Read data at idx
  output logic perr // Check mismatch at idx
);
  localparam int PW = W / l2c_pkg::LANE;

  logic [PW+W-1:0] mem [2**IW];

  function automatic logic [PW-1:0] par(input logic [W-1:0] d);
    logic [PW-1:0] p;
    p = '0;
    for (int i = 0; i < PW; i++) begin
      p[i] = ^d[i*l2c_pkg::LANE +: l2c_pkg::LANE];
    end
    return p;
  endfunction : par

  // Lane parity; inject flips the check bit of lane 0 so readers see an error
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[idx] <= {par(wdata) ^ PW'(inject), wdata}; // [R19]
    end
  end

  assign rdata = mem[idx][W-1:0];
  assign perr = |(par(mem[idx][W-1:0]) ^ mem[idx][W +: PW]);
endmodule : l2c_store

// ---- hdl/l2c_top.sv ----
// Notes on behaviour
// [R1] Four banks, 512 sets, 16 ways each
// [R2] Each way holds one 64-byte line
// [R3] Every bank has its own 128-bit port
// [R4] Different banks serve requests concurrently
// [R5] One shared 128-bit outer port to DDR
// [R6] Directory tracks sharers and probes on writes
// [R7] Disabled ways readable and writable through window
// [R8] Window accesses always hit in one cycle
// [R9] Window access beats cache access in bank
// [R10] After reset only way 0 caches
// [R11] Software writes enable more ways; applied
// [R12] Enabled way stays enabled until reset
// [R13] Highest way lowest window address, way 1 top
// [R14] Enabled way's slice leaves the window
// [R15] Scratchpad range allocates without memory fetch
// [R16] Scratchpad allocates only enabled unmasked ways
// [R17] Scratchpad eviction discards data; avoid evicting
// [R18] Scratchpad lines are cacheable and tracked
// [R19] Way mask, lock, parity check, error reporting
// [R20] Disabled way is one contiguous slice, way order
module l2c_top #(
  parameter int NB = l2c_pkg::NB,
  parameter int SETS = l2c_pkg::SETS,
  parameter int WAYS = l2c_pkg::WAYS,
  parameter int DW = l2c_pkg::DW,
  parameter int AW = l2c_pkg::AW,
  parameter int NM = l2c_pkg::NM,
  parameter int MW = l2c_pkg::MW
) (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Complex reset, sync high
  input wire logic [NB-1:0] in_req, // Inner request, held to ack
  input wire logic [NB-1:0] in_we, // Inner write
  input wire logic [NB-1:0][AW-1:0] in_addr, // Inner address
  input wire logic [NB-1:0][DW-1:0] in_wdata, // Inner write data
  input wire logic [NB-1:0][MW-1:0] in_src, // Requesting master
  output logic [NB-1:0] in_ack, // Inner answer pulse
  output logic [NB-1:0] in_err, // Inner answer is an error
  output logic [NB-1:0][DW-1:0] in_rdata, // Inner read data
  input wire logic win_req, // Window request, held to ack
  input wire logic win_we, // Window write
  input wire logic [AW-1:0] win_addr, // Window address
  input wire logic [DW-1:0] win_wdata, // Window write data
  output logic win_ack, // Window answer pulse
  output logic win_err, // Window answer is an error
  output logic [DW-1:0] win_rdata, // Window read data
  output logic out_req, // Outer beat request
  output logic out_we, // Outer write
  output logic [AW-1:0] out_addr, // Outer beat address
  output logic [DW-1:0] out_wdata, // Outer write data
  input wire logic out_ack, // Outer beat done
  input wire logic [DW-1:0] out_rdata, // Outer read data
  input wire logic way_en_wr, // Way enable write strobe
  input wire logic [WAYS-1:0] way_en_wdata, // Ways to enable
  input wire logic [WAYS-1:0] way_mask, // Ways barred from allocation
  input wire logic [WAYS-1:0] way_lock, // Ways never evicted
  input wire logic ecc_inject, // Corrupt every word stored while high
  output logic [WAYS-1:0] way_en, // Current way enables
  output logic [NB-1:0] prb_v, // Probe pulse per bank
  output logic [NB-1:0][NM-1:0] prb_m, // Masters to invalidate
  output logic [NB-1:0][AW-1:0] prb_a, // Line address to invalidate
  output logic ecc_err, // Check error pulse
  output logic [l2c_pkg::ECW-1:0] ecc_cnt // Saturating error count
);
  localparam int BEATS = l2c_pkg::LINE_B * 8 / DW;
  localparam int OFFW = $clog2(DW / 8);
  localparam int BTW = $clog2(BEATS);
  localparam int BKW = $clog2(NB);
  localparam int SW = $clog2(SETS);
  localparam int WYW = $clog2(WAYS);
  localparam int BANK_LSB = OFFW + BTW;
  localparam int SET_LSB = BANK_LSB + BKW;
  localparam int TAG_LSB = SET_LSB + SW;
  localparam int TW = AW - TAG_LSB;
  localparam int IDXW = WYW + SW + BTW;
  localparam logic [AW-1:0] WIN_SIZE = AW'(WAYS - 1) << TAG_LSB;

  typedef struct packed {
    l2c_pkg::l2c_bst_t st;
    logic [BTW-1:0] beat;
    logic [WYW-1:0] way;
    logic [SW-1:0] set;
    logic [TW-1:0] vtag;
    logic [TW-1:0] ctag;
    logic scr;
    logic [WYW-1:0] rr;
    logic [BEATS-1:0][DW-1:0] lbuf;
  } l2c_bank_t;

  typedef struct packed {
    l2c_bank_t [NB-1:0] bk;
    logic o_act;
    logic [BKW-1:0] o_bank;
    logic [BTW-1:0] o_beat;
    logic [BKW-1:0] o_rr;
    logic [NB-1:0] in_ack;
    logic [NB-1:0] in_err;
    logic [NB-1:0][DW-1:0] in_rdata;
    logic win_ack;
    logic win_err;
    logic [DW-1:0] win_rdata;
    logic out_req;
    logic out_we;
    logic [AW-1:0] out_addr;
    logic [DW-1:0] out_wdata;
    logic [NB-1:0] prb_v;
    logic [NB-1:0][NM-1:0] prb_m;
    logic [NB-1:0][AW-1:0] prb_a;
    logic ecc_err;
    logic [l2c_pkg::ECW-1:0] ecc_cnt;
  } l2c_state_t;

  l2c_state_t st_ff;
  l2c_state_t nxt_st;

  logic [IDXW-1:0] m_idx [NB];
  logic [NB-1:0] m_we;
  logic [DW-1:0] m_wd [NB];
  logic [DW-1:0] m_rd [NB];
  logic [NB-1:0] m_perr;
  logic [NB-1:0] tag_we;
  logic [WYW-1:0] t_way [NB];
  logic [SW-1:0] t_set [NB];
  l2c_pkg::l2c_tag_t tag_wd [NB];
  logic [NB-1:0] vld_we;
  logic [NB-1:0] vld_val;
  l2c_pkg::l2c_tag_t tag_mem [NB][SETS*WAYS];
  logic [WAYS-1:0] vld [NB][SETS];

  function automatic logic [IDXW-1:0] midx(input logic [WYW-1:0] w, input logic [SW-1:0] s,
                                           input logic [BTW-1:0] bt);
    return {w, s, bt};
  endfunction : midx

  function automatic logic [AW-1:0] laddr(input logic [TW-1:0] t, input logic [SW-1:0] s,
                                          input logic [BKW-1:0] bk);
    return {t, s, bk, {(BTW + OFFW){1'b0}}};
  endfunction : laddr

  // Victim: first free candidate from the pointer, else next candidate
  function automatic logic [WYW-1:0] pick(input logic [WAYS-1:0] cand, input logic [WAYS-1:0] v,
                                          input logic [WYW-1:0] rr);
    logic [WYW-1:0] r;
    logic [WYW-1:0] k;
    logic f;
    r = rr;
    f = 1'b0;
    for (int i = 0; i < WAYS; i++) begin
      k = rr + WYW'(i);
      if (!f && cand[k] && !v[k]) begin
        r = k;
        f = 1'b1;
      end
    end
    for (int i = 0; i < WAYS; i++) begin
      k = rr + WYW'(i);
      if (!f && cand[k]) begin
        r = k;
        f = 1'b1;
      end
    end
    return r;
  endfunction : pick

  l2c_way_ctl #(.WAYS(WAYS)) u_way (
    .core_clk(core_clk),
    .rst(rst),
    .en_wr(way_en_wr),
    .en_wdata(way_en_wdata),
    .way_en(way_en)
  );

  for (genvar g = 0; g < NB; g++) begin : g_bank
    l2c_store #(.W(DW), .IW(IDXW)) u_store ( // [R1] [R2]
      .core_clk(core_clk),
      .idx(m_idx[g]),
      .we(m_we[g]),
      .wdata(m_wd[g]),
      .inject(ecc_inject),
      .rdata(m_rd[g]),
      .perr(m_perr[g])
    );
  end

  // Window decode: way WAYS-1 at the base, way 1 at the top slice
  logic w_take;
  logic [AW-1:0] w_off;
  logic w_in;
  logic [WYW-1:0] w_way;
  logic w_ok;
  logic [BKW-1:0] w_bank;
  assign w_take = win_req && !st_ff.win_ack;
  assign w_off = win_addr - l2c_pkg::WIN_BASE;
  assign w_in = win_addr >= l2c_pkg::WIN_BASE && w_off < WIN_SIZE;
  assign w_way = WYW'(WAYS - 1) - w_off[TAG_LSB +: WYW]; // [R13] [R20]
  assign w_ok = w_take && w_in && !way_en[w_way]; // [R7] [R14]
  assign w_bank = w_off[BANK_LSB +: BKW];

  always_comb begin
    logic [AW-1:0] a;
    l2c_pkg::l2c_rgn_t rg;
    logic [SW-1:0] s;
    logic [TW-1:0] tg;
    logic hit;
    logic [WYW-1:0] hw;
    logic [WYW-1:0] vw;
    l2c_pkg::l2c_tag_t te;
    logic [WAYS-1:0] cand;
    logic [NM-1:0] sb;
    logic [BKW-1:0] ob;
    logic fnd;
    a = '0;
    rg = l2c_pkg::RG_NONE;
    s = '0;
    tg = '0;
    hit = 1'b0;
    hw = '0;
    vw = '0;
    te = '0;
    cand = '0;
    sb = '0;
    ob = st_ff.o_bank;
    fnd = 1'b0;
    nxt_st = st_ff;
    nxt_st.in_ack = '0;
    nxt_st.in_err = '0;
    nxt_st.prb_v = '0;
    nxt_st.win_ack = 1'b0;
    nxt_st.win_err = 1'b0;
    nxt_st.ecc_err = 1'b0;
    m_we = '0;
    tag_we = '0;
    vld_we = '0;
    vld_val = '0;
    for (int b = 0; b < NB; b++) begin
      m_idx[b] = midx(st_ff.bk[b].way, st_ff.bk[b].set, st_ff.bk[b].beat);
      m_wd[b] = st_ff.bk[b].lbuf[st_ff.bk[b].beat];
      t_way[b] = st_ff.bk[b].way;
      t_set[b] = st_ff.bk[b].set;
      tag_wd[b] = '0;
    end
    if (w_take) begin
      nxt_st.win_ack = 1'b1; // [R8]
      nxt_st.win_err = !w_ok;
    end
    for (int b = 0; b < NB; b++) begin
      if (w_ok && w_bank == BKW'(b)) begin
        // Window owns the bank this cycle; the cache side waits
        m_idx[b] = midx(w_way, w_off[SET_LSB +: SW], w_off[OFFW +: BTW]); // [R9] [R7]
        m_we[b] = win_we;
        m_wd[b] = win_wdata;
        nxt_st.win_rdata = m_rd[b];
        nxt_st.ecc_err = nxt_st.ecc_err | (!win_we && m_perr[b]);
      end else begin
        case (st_ff.bk[b].st)
          l2c_pkg::ST_IDLE: begin
            if (in_req[b] && !st_ff.in_ack[b]) begin // [R3] [R4]
              a = in_addr[b];
              rg = l2c_pkg::rgn_of(a);
              s = a[SET_LSB +: SW];
              tg = a[TAG_LSB +: TW];
              sb = NM'(1) << in_src[b];
              hit = 1'b0;
              hw = '0;
              for (int w = 0; w < WAYS; w++) begin
                if (vld[b][s][w] && way_en[w] && tag_mem[b][{s, WYW'(w)}].tag == tg) begin
                  hit = 1'b1;
                  hw = WYW'(w);
                end
              end
              te = tag_mem[b][{s, hw}];
              cand = way_en & ~way_mask & ~way_lock; // [R16] [R19]
              if (rg == l2c_pkg::RG_NONE || a[BANK_LSB +: BKW] != BKW'(b)) begin
                nxt_st.in_ack[b] = 1'b1;
                nxt_st.in_err[b] = 1'b1;
              end else if (hit) begin
                m_idx[b] = midx(hw, s, a[OFFW +: BTW]);
                tag_we[b] = 1'b1;
                t_way[b] = hw;
                t_set[b] = s;
                tag_wd[b] = te;
                nxt_st.in_ack[b] = 1'b1;
                if (in_we[b]) begin
                  m_we[b] = 1'b1;
                  m_wd[b] = in_wdata[b];
                  tag_wd[b].dirty = 1'b1;
                  tag_wd[b].shr = sb; // [R6] [R18]
                  nxt_st.prb_v[b] = (te.shr & ~sb) != '0;
                  nxt_st.prb_m[b] = te.shr & ~sb;
                  nxt_st.prb_a[b] = laddr(tg, s, BKW'(b));
                end else begin
                  tag_wd[b].shr = te.shr | sb; // [R6]
                  nxt_st.in_rdata[b] = m_rd[b];
                  nxt_st.ecc_err = nxt_st.ecc_err | m_perr[b];
                end
              end else if (cand == '0) begin
                nxt_st.in_ack[b] = 1'b1;
                nxt_st.in_err[b] = 1'b1;
              end else begin
                vw = pick(cand, vld[b][s], st_ff.bk[b].rr);
                te = tag_mem[b][{s, vw}];
                nxt_st.bk[b].way = vw;
                nxt_st.bk[b].set = s;
                nxt_st.bk[b].vtag = te.tag;
                nxt_st.bk[b].ctag = tg;
                nxt_st.bk[b].scr = rg == l2c_pkg::RG_SCR;
                nxt_st.bk[b].beat = '0;
                nxt_st.bk[b].rr = vw + WYW'(1);
                nxt_st.bk[b].lbuf = '0;
                vld_we[b] = 1'b1;
                t_way[b] = vw;
                t_set[b] = s;
                nxt_st.prb_v[b] = vld[b][s][vw] && te.shr != '0; // [R6]
                nxt_st.prb_m[b] = te.shr;
                nxt_st.prb_a[b] = laddr(te.tag, s, BKW'(b));
                if (vld[b][s][vw] && te.dirty && !te.scr) begin
                  nxt_st.bk[b].st = l2c_pkg::ST_RDLINE;
                end else if (rg == l2c_pkg::RG_SCR) begin
                  nxt_st.bk[b].st = l2c_pkg::ST_WRLINE; // [R15] [R17]
                end else begin
                  nxt_st.bk[b].st = l2c_pkg::ST_FETCH;
                end
              end
            end
          end
          l2c_pkg::ST_RDLINE: begin
            nxt_st.bk[b].lbuf[st_ff.bk[b].beat] = m_rd[b];
            nxt_st.ecc_err = nxt_st.ecc_err | m_perr[b];
            nxt_st.bk[b].beat = st_ff.bk[b].beat + BTW'(1);
            if (st_ff.bk[b].beat == BTW'(BEATS - 1)) begin
              nxt_st.bk[b].st = l2c_pkg::ST_WBACK;
            end
          end
          l2c_pkg::ST_WRLINE: begin
            m_we[b] = 1'b1;
            nxt_st.bk[b].beat = st_ff.bk[b].beat + BTW'(1);
            if (st_ff.bk[b].beat == BTW'(BEATS - 1)) begin
              tag_we[b] = 1'b1;
              tag_wd[b].scr = st_ff.bk[b].scr;
              tag_wd[b].tag = st_ff.bk[b].ctag;
              vld_we[b] = 1'b1;
              vld_val[b] = 1'b1;
              nxt_st.bk[b].st = l2c_pkg::ST_IDLE;
            end
          end
          default: ;
        endcase
      end
    end
    // Outer port: one bank owns it for a whole line, banks in turn
    if (!st_ff.o_act) begin
      for (int i = 0; i < NB; i++) begin
        ob = st_ff.o_rr + BKW'(i);
        if (!fnd && (st_ff.bk[ob].st == l2c_pkg::ST_WBACK || st_ff.bk[ob].st == l2c_pkg::ST_FETCH)) begin
          fnd = 1'b1;
          nxt_st.o_act = 1'b1;
          nxt_st.o_bank = ob;
          nxt_st.o_beat = '0;
          nxt_st.out_req = 1'b1; // [R5]
          nxt_st.out_we = st_ff.bk[ob].st == l2c_pkg::ST_WBACK;
          nxt_st.out_addr = laddr(nxt_st.out_we ? st_ff.bk[ob].vtag : st_ff.bk[ob].ctag, st_ff.bk[ob].set, ob);
          nxt_st.out_wdata = st_ff.bk[ob].lbuf[0];
        end
      end
    end else if (out_ack) begin
      if (!st_ff.out_we) begin
        nxt_st.bk[ob].lbuf[st_ff.o_beat] = out_rdata;
      end
      if (st_ff.o_beat == BTW'(BEATS - 1)) begin
        nxt_st.out_req = 1'b0;
        nxt_st.o_act = 1'b0;
        nxt_st.o_rr = ob + BKW'(1);
        nxt_st.bk[ob].beat = '0;
        if (st_ff.bk[ob].st == l2c_pkg::ST_WBACK && !st_ff.bk[ob].scr) begin
          nxt_st.bk[ob].st = l2c_pkg::ST_FETCH;
        end else begin
          nxt_st.bk[ob].st = l2c_pkg::ST_WRLINE;
          if (st_ff.bk[ob].st == l2c_pkg::ST_WBACK) begin
            nxt_st.bk[ob].lbuf = '0;
          end
        end
      end else begin
        nxt_st.o_beat = st_ff.o_beat + BTW'(1);
        nxt_st.out_addr = st_ff.out_addr + AW'(DW / 8);
        nxt_st.out_wdata = st_ff.bk[ob].lbuf[st_ff.o_beat + BTW'(1)];
      end
    end
    if (nxt_st.ecc_err && st_ff.ecc_cnt != '1) begin
      nxt_st.ecc_cnt = st_ff.ecc_cnt + l2c_pkg::ECW'(1); // [R19]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff <= '0;
      for (int b = 0; b < NB; b++) begin
        st_ff.bk[b].st <= l2c_pkg::ST_IDLE;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge core_clk) begin
    for (int b = 0; b < NB; b++) begin
      if (tag_we[b]) begin
        tag_mem[b][{t_set[b], t_way[b]}] <= tag_wd[b];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    for (int b = 0; b < NB; b++) begin
      for (int s = 0; s < SETS; s++) begin
        if (rst) begin
          vld[b][s] <= '0;
        end else if (vld_we[b] && t_set[b] == SW'(s)) begin
          vld[b][s][t_way[b]] <= vld_val[b];
        end
      end
    end
  end

  assign in_ack = st_ff.in_ack;
  assign in_err = st_ff.in_err;
  assign in_rdata = st_ff.in_rdata;
  assign win_ack = st_ff.win_ack;
  assign win_err = st_ff.win_err;
  assign win_rdata = st_ff.win_rdata;
  assign out_req = st_ff.out_req;
  assign out_we = st_ff.out_we;
  assign out_addr = st_ff.out_addr;
  assign out_wdata = st_ff.out_wdata;
  assign prb_v = st_ff.prb_v;
  assign prb_m = st_ff.prb_m;
  assign prb_a = st_ff.prb_a;
  assign ecc_err = st_ff.ecc_err;
  assign ecc_cnt = st_ff.ecc_cnt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_win_hit_latency: assert property (w_take |=> win_ack) // [R8]
    else $error("window access not answered next cycle");
  a_win_shrink: assert property (w_take && w_in && way_en[w_way] |=> win_ack && win_err) // [R14]
    else $error("window reached an enabled way");
  a_out_hold: assert property (out_req && !out_ack |=> out_req && $stable(out_addr) && $stable(out_we)) // [R5]
    else $error("outer request changed before ack");
  a_line_end: assert property (out_req && out_ack && out_addr[OFFW +: BTW] == BTW'(BEATS - 1) |=> !out_req) // [R2]
    else $error("outer line longer than one block");
  a_scr_discard: assert property (out_req |-> l2c_pkg::rgn_of(out_addr) != l2c_pkg::RG_SCR) // [R17]
    else $error("scratchpad line went to memory");
  for (genvar g = 0; g < NB; g++) begin : g_chk
    a_win_first: assert property (w_ok && w_bank == BKW'(g) && in_req[g] && !in_ack[g] |=> !in_ack[g]) // [R9]
      else $error("cache access beat window access");
    a_bank_indep: assert property (in_req[g] && !in_ack[g] && st_ff.bk[g].st == l2c_pkg::ST_IDLE // [R4]
      && !(w_ok && w_bank == BKW'(g)) |=> in_ack[g] || st_ff.bk[g].st != l2c_pkg::ST_IDLE)
      else $error("idle bank did not take its request");
    a_alloc_way: assert property (st_ff.bk[g].st == l2c_pkg::ST_IDLE && nxt_st.bk[g].st != l2c_pkg::ST_IDLE // [R16]
      |-> way_en[nxt_st.bk[g].way] && !way_mask[nxt_st.bk[g].way])
      else $error("allocation into disabled or masked way");
  end

  c_win_access: cover property (w_ok ##1 win_ack);
  c_fill: cover property (st_ff.bk[0].st == l2c_pkg::ST_FETCH ##[1:40] st_ff.bk[0].st == l2c_pkg::ST_WRLINE);
  c_wback: cover property (out_req && out_we && out_ack);
  c_scr_alloc: cover property (st_ff.bk[0].st == l2c_pkg::ST_IDLE && nxt_st.bk[0].scr
    && nxt_st.bk[0].st == l2c_pkg::ST_WRLINE);
endmodule : l2c_top

// ---- hdl/l2c_way_ctl.sv ----
module l2c_way_ctl #(
  parameter int WAYS = l2c_pkg::WAYS
) (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Complex reset, sync high
  input wire logic en_wr, // Enable-write strobe
  input wire logic [WAYS-1:0] en_wdata, // Ways to enable
  output logic [WAYS-1:0] way_en // Ways used as cache
);
  typedef struct packed {
    logic [WAYS-1:0] en;
  } l2c_wst_t;

  l2c_wst_t st_ff;
  l2c_wst_t nxt_st;

  // Enables only accumulate; zero bits never clear a way
  always_comb begin
    nxt_st = st_ff;
    if (en_wr) begin
      nxt_st.en = st_ff.en | en_wdata; // [R11] [R12]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff.en <= WAYS'(l2c_pkg::WAY_EN_RST); // [R10]
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign way_en = st_ff.en;

  a_way0_reset: assert property (@(posedge core_clk) rst |=> way_en == WAYS'(l2c_pkg::WAY_EN_RST)) // [R10]
    else $error("way enables wrong after reset");
  a_en_sticky: assert property (@(posedge core_clk) disable iff (rst) // [R12]
    !$past(rst) |-> ($past(way_en) & ~way_en) == '0)
    else $error("an enabled way was disabled");
  a_en_apply: assert property (@(posedge core_clk) disable iff (rst) // [R11]
    en_wr |=> (way_en & $past(en_wdata)) == $past(en_wdata))
    else $error("way enable write not applied");
endmodule : l2c_way_ctl

// ---- shared/l2c_pkg.sv ----
package l2c_pkg;
  // Default geometry
  localparam int NB = 4;
  localparam int SETS = 512;
  localparam int WAYS = 16;
  localparam int LINE_B = 64;
  localparam int DW = 128;
  localparam int AW = 32;
  localparam int NM = 5;
  localparam int MW = 3;
  localparam int LANE = 32;
  localparam int ECW = 16;
  // Address map of the regions the controller decodes
  localparam logic [31:0] DDR_BASE = 32'h8000_0000;
  localparam logic [31:0] SCR_BASE = 32'h0A00_0000;
  localparam logic [31:0] SCR_SIZE = 32'h0020_0000;
  localparam logic [31:0] WIN_BASE = 32'h0800_0000;
  localparam logic [WAYS-1:0] WAY_EN_RST = 16'h0001;

  typedef struct packed {
    logic dirty;
    logic scr;
    logic [14:0] tag;
    logic [NM-1:0] shr;
  } l2c_tag_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RDLINE = 5'h02,
    ST_WBACK = 5'h04,
    ST_FETCH = 5'h08,
    ST_WRLINE = 5'h10
  } l2c_bst_t;

  typedef enum logic [2:0] {
    RG_NONE = 3'h1,
    RG_DDR = 3'h2,
    RG_SCR = 3'h4
  } l2c_rgn_t;

  function automatic l2c_rgn_t rgn_of(input logic [31:0] a);
    if (a >= DDR_BASE) return RG_DDR;
    if (a >= SCR_BASE && a - SCR_BASE < SCR_SIZE) return RG_SCR;
    return RG_NONE;
  endfunction : rgn_of
endpackage : l2c_pkg
